// file: hw/cbie_exec.sv
// Executor for loop-count branch, global irq enable and threaded entry.
// Assumes the sequencer holds opcode/operand stable while START_I pulses
// and that register file and code memory answer reads in the same cycle.
module cbie_exec import cbie_pkg::*; #(
	parameter int LINES = CBIE_IRQ_LINES
) (
	input wire logic SYS_CLK_I,
	input wire logic RESET_I,
	input wire logic START_I,
	input wire logic [7:0] OPCODE_I,
	input wire logic [7:0] DISP_I,
	input wire logic [15:0] PC_I,
	input wire logic [7:0] WREG_RD_I,
	input wire logic [7:0] CODE_RD_I,
	input wire logic [LINES-1:0] IRQ_PENDING_I,
	input wire logic [7:0] FLAGS_I,
	output logic BUSY_O,
	output logic DONE_O,
	output logic [3:0] WREG_SEL_O,
	output logic WREG_WE_O,
	output logic [7:0] WREG_WD_O,
	output logic PC_WE_O,
	output logic [15:0] PC_O,
	output logic [15:0] CODE_ADDR_O,
	output logic STACK_WE_O,
	output logic [15:0] STACK_ADDR_O,
	output logic [7:0] STACK_WD_O,
	output logic [15:0] STACK_POINTER_O,
	output logic [15:0] INSTRUCTION_POINTER_O,
	output logic [7:0] SYSTEM_MODE_REG_O,
	output logic [7:0] FLAGS_O,
	output logic IRQ_TAKE_O,
	output logic [LINES-1:0] IRQ_GRANT_O
);
	// ***************************************************************
	// Decode and sequencing
	// ***************************************************************
	cbie_state_e state;
	logic [3:0] cycles;
	logic [15:0] stack_pointer;
	logic [15:0] instruction_pointer;
	logic [7:0] system_mode_reg;
	logic [7:0] code_hi;
	logic [7:0] next_count;
	logic [15:0] next_target;
	logic is_loop, is_irq_en, is_enter;

	assign is_loop = OPCODE_I[3:0] == CBIE_LOOP_OP_LO;
	assign is_irq_en = OPCODE_I == CBIE_IRQ_EN_OP;
	assign is_enter = OPCODE_I == CBIE_ENTER_OP;
	assign next_count = WREG_RD_I - 8'h01;
	// PC_I already points past the displacement byte
	assign next_target = PC_I + {{8{DISP_I[7]}}, DISP_I};

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			state <= CBIE_IDLE;
			cycles <= 4'h0;
		end else begin
			case (state)
			CBIE_IDLE: begin
				if (START_I && is_loop) begin
					state <= CBIE_LOOP;
					cycles <= CBIE_LOOP_CYCLES - 4'h2;
				end else if (START_I && is_enter) begin
					state <= CBIE_PUSH_HI;
					cycles <= CBIE_ENTER_CYCLES - 4'h5;
				end else if (START_I && is_irq_en) begin
					state <= CBIE_WAIT;
					// One cycle longer than the loop path: WAIT is entered directly
					cycles <= CBIE_IRQ_EN_CYCLES - 4'h1;
				end
			end
			CBIE_LOOP: state <= CBIE_WAIT;
			CBIE_PUSH_HI: state <= CBIE_PUSH_LO;
			CBIE_PUSH_LO: state <= CBIE_FETCH_HI;
			CBIE_FETCH_HI: state <= CBIE_FETCH_LO;
			CBIE_FETCH_LO: state <= CBIE_WAIT;
			CBIE_WAIT: begin
				if (cycles == 4'h1) begin
					state <= CBIE_IDLE;
				end
				cycles <= cycles - 4'h1;
			end
			default: state <= CBIE_IDLE;
			endcase
		end
	end

	assign BUSY_O = state != CBIE_IDLE;
	assign DONE_O = state == CBIE_WAIT && cycles == 4'h1;

	// ***************************************************************
	// Loop counter write-back and branch
	// ***************************************************************
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			WREG_SEL_O <= 4'h0;
			WREG_WE_O <= 1'b0;
			WREG_WD_O <= 8'h00;
		end else begin
			WREG_WE_O <= 1'b0;
			if (state == CBIE_IDLE && START_I && is_loop) begin
				WREG_SEL_O <= OPCODE_I[7:4];
				WREG_WE_O <= 1'b1;
				WREG_WD_O <= next_count;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			PC_WE_O <= 1'b0;
			PC_O <= CBIE_PTR_RST;
		end else begin
			PC_WE_O <= 1'b0;
			if (state == CBIE_IDLE && START_I && is_loop) begin
				PC_O <= next_target;
				PC_WE_O <= next_count != 8'h00;
			end else if (state == CBIE_FETCH_LO) begin
				PC_O <= {code_hi, CODE_RD_I};
				PC_WE_O <= 1'b1;
			end
		end
	end

	// ***************************************************************
	// Threaded entry: push pointer, swap, fetch vector
	// ***************************************************************
	// The low byte is stored at the lowered stack pointer plus one
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			STACK_WE_O <= 1'b0;
			STACK_ADDR_O <= CBIE_PTR_RST;
			STACK_WD_O <= 8'h00;
		end else begin
			STACK_WE_O <= 1'b0;
			if (state == CBIE_PUSH_HI) begin
				STACK_WE_O <= 1'b1;
				STACK_ADDR_O <= stack_pointer;
				STACK_WD_O <= instruction_pointer[15:8];
			end else if (state == CBIE_PUSH_LO) begin
				STACK_WE_O <= 1'b1;
				STACK_ADDR_O <= stack_pointer + 16'h0001;
				STACK_WD_O <= instruction_pointer[7:0];
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			stack_pointer <= CBIE_PTR_RST;
		end else if (state == CBIE_IDLE && START_I && is_enter) begin
			stack_pointer <= stack_pointer - CBIE_PTR_STEP;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			instruction_pointer <= CBIE_PTR_RST;
		end else if (state == CBIE_PUSH_LO) begin
			instruction_pointer <= PC_I;
		end else if (state == CBIE_FETCH_LO) begin
			instruction_pointer <= instruction_pointer + CBIE_PTR_STEP;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			code_hi <= 8'h00;
		end else if (state == CBIE_FETCH_HI) begin
			code_hi <= CODE_RD_I;
		end
	end

	assign CODE_ADDR_O = (state == CBIE_FETCH_LO) ?
		instruction_pointer + 16'h0001 : instruction_pointer;
	assign STACK_POINTER_O = stack_pointer;
	assign INSTRUCTION_POINTER_O = instruction_pointer;

	// ***************************************************************
	// System mode and flags
	// ***************************************************************
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			system_mode_reg <= CBIE_SYS_MODE_RST;
		end else if (state == CBIE_IDLE && START_I && is_irq_en) begin
			system_mode_reg[CBIE_IRQ_EN_BIT] <= 1'b1;
		end
	end
	assign SYSTEM_MODE_REG_O = system_mode_reg;

	// Flags pass straight through: nothing here ever writes them
	assign FLAGS_O = FLAGS_I;

	cbie_irq_pick #(
		.LINES(LINES)
	) u_pick (
		.pending_i(IRQ_PENDING_I),
		.enable_i(system_mode_reg[CBIE_IRQ_EN_BIT] && !BUSY_O),
		.take_o(IRQ_TAKE_O),
		.grant_o(IRQ_GRANT_O)
	);

	// ***************************************************************
	// Checks
	// ***************************************************************
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (RESET_I);

	a_loop_write: assert property (
		state == CBIE_IDLE && START_I && is_loop
		|=> WREG_WE_O && WREG_WD_O == $past(WREG_RD_I) - 8'h01)
		else $error("loop counter not decremented");
	a_loop_branch: assert property (
		state == CBIE_IDLE && START_I && is_loop
		|=> PC_WE_O == ($past(WREG_RD_I) != 8'h01))
		else $error("branch decision wrong");
	a_loop_target: assert property (
		state == CBIE_IDLE && START_I && is_loop
		|=> PC_O == $past(PC_I) + {{8{$past(DISP_I[7])}}, $past(DISP_I)})
		else $error("branch target wrong");
	a_loop_len: assert property (
		state == CBIE_IDLE && START_I && is_loop |-> ##7 DONE_O)
		else $error("loop instruction length wrong");
	a_flags_kept: assert property (FLAGS_O == FLAGS_I)
		else $error("flags altered");
	a_irq_enable: assert property (
		state == CBIE_IDLE && START_I && is_irq_en
		|=> system_mode_reg[0] && system_mode_reg[7:1] ==
		$past(system_mode_reg[7:1]))
		else $error("enable bit handling wrong");
	a_irq_len: assert property (
		state == CBIE_IDLE && START_I && is_irq_en |-> ##3 DONE_O)
		else $error("enable instruction length wrong");
	a_irq_serve: assert property (
		system_mode_reg[0] && !BUSY_O && |IRQ_PENDING_I |-> IRQ_TAKE_O)
		else $error("pending request not serviced");
	a_enter_sp: assert property (
		state == CBIE_IDLE && START_I && is_enter
		|=> stack_pointer == $past(stack_pointer) - 16'h0002)
		else $error("stack pointer not lowered by two");
	a_enter_ip: assert property (
		state == CBIE_PUSH_LO
		|=> instruction_pointer == $past(PC_I) ##2
		instruction_pointer == $past(PC_I, 3) + 16'h0002)
		else $error("instruction pointer sequence wrong");
	a_enter_pc: assert property (
		state == CBIE_FETCH_HI
		|=> ##1 PC_WE_O && PC_O == {$past(CODE_RD_I, 2),
		$past(CODE_RD_I)})
		else $error("vector load wrong");
	a_enter_len: assert property (
		state == CBIE_IDLE && START_I && is_enter |-> ##13 DONE_O)
		else $error("entry length wrong");

	c_loop_taken: cover property (PC_WE_O && state == CBIE_LOOP);
	c_loop_fall: cover property (WREG_WE_O && !PC_WE_O);
	c_irq_en: cover property (state == CBIE_IDLE && START_I && is_irq_en);
	c_enter_done: cover property (state == CBIE_FETCH_LO ##9 DONE_O);
endmodule : cbie_exec

// file: inc/cbie_pkg.sv
// Constants and types for the count-branch, irq-enable and enter executor.
// Assumes an 8-bit core with byte-wide data and 16-bit code addresses.
package cbie_pkg;
	localparam logic [3:0] CBIE_LOOP_OP_LO = 4'ha;
	localparam logic [7:0] CBIE_IRQ_EN_OP = 8'h9f;
	localparam logic [7:0] CBIE_ENTER_OP = 8'h1f;
	localparam int CBIE_IRQ_EN_BIT = 0;
	localparam logic [7:0] CBIE_SYS_MODE_RST = 8'h00;
	localparam logic [15:0] CBIE_PTR_RST = 16'h0000;
	localparam logic [15:0] CBIE_PTR_STEP = 16'h0002;
	localparam logic [3:0] CBIE_LOOP_CYCLES = 4'h8;
	localparam logic [3:0] CBIE_IRQ_EN_CYCLES = 4'h4;
	localparam logic [3:0] CBIE_ENTER_CYCLES = 4'he;
	localparam int CBIE_IRQ_LINES = 8;
	typedef enum logic [2:0] {
		CBIE_IDLE, CBIE_LOOP, CBIE_PUSH_HI, CBIE_PUSH_LO,
		CBIE_FETCH_HI, CBIE_FETCH_LO, CBIE_WAIT
	} cbie_state_e;
endpackage : cbie_pkg

// file: hw/cbie_irq_pick.sv
// Priority picker for pending interrupt requests.
// Assumes line 0 has the highest priority.
module cbie_irq_pick import cbie_pkg::*; #(
	parameter int LINES = CBIE_IRQ_LINES
) (
	input wire logic [LINES-1:0] pending_i,
	input wire logic enable_i,
	output logic take_o,
	output logic [LINES-1:0] grant_o
);
	logic [LINES:0] blocked;
	assign blocked[0] = ~enable_i;
	genvar g;
	generate
		for (g = 0; g < LINES; g++) begin : g_line
			assign grant_o[g] = pending_i[g] & ~blocked[g];
			assign blocked[g+1] = blocked[g] | pending_i[g];
		end
	endgenerate
	assign take_o = |grant_o;
endmodule : cbie_irq_pick

// file: tb/cbie_partner.sv
// Register file, code memory and stack beside the executor.
// Assumes writes land on the rising edge and reads answer at once.
module cbie_partner (
	input wire logic clk_i,
	input wire logic [3:0] rd_sel_i,
	output logic [7:0] rd_data_o,
	input wire logic wr_en_i,
	input wire logic [3:0] wr_sel_i,
	input wire logic [7:0] wr_data_i,
	input wire logic [15:0] code_addr_i,
	output logic [7:0] code_data_o,
	input wire logic stack_en_i,
	input wire logic [15:0] stack_addr_i,
	input wire logic [7:0] stack_data_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] wreg [16];
	logic [7:0] code [65536];
	logic [7:0] stack [65536];
	int seed = 32'h7ba48e2c;
	initial begin
		for (int i = 0; i < 16; i++) wreg[i] = 8'($random(seed));
		for (int i = 0; i < 65536; i++) code[i] = 8'($random(seed));
	end
	assign rd_data_o = wreg[rd_sel_i];
	assign code_data_o = code[code_addr_i];
	always @(posedge clk_i) begin
		if (wr_en_i) wreg[wr_sel_i] <= wr_data_i;
		if (stack_en_i) stack[stack_addr_i] <= stack_data_i;
	end
endmodule : cbie_partner

// file: tb/cbie_exec_bench.sv
// Self-checking bench for the loop-count, irq-enable and entry executor.
// Assumes the partner model holds opcode-selected register and code data.
module cbie_exec_bench import cbie_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, start = 0, busy, done, wwe, pwe, swe, take;
	logic [7:0] op = 0, disp = 0, flags = 0, pend = 0, wrd, crd, wwd, swd;
	logic [7:0] mode, flgo, grant, r, emode = CBIE_SYS_MODE_RST;
	logic [15:0] pc = 0, cad, sad, sp, ip, pco;
	logic [15:0] esp = CBIE_PTR_RST, eip = CBIE_PTR_RST;
	logic [3:0] wsel;
	logic [43:0] q[$];
	int bad_count = 0, cmp_count = 0, seed = 32'h7ba48e2c, n;
	bit irq_on = 0;
	always #2 clk = ~clk;
	cbie_exec dut (.SYS_CLK_I(clk), .RESET_I(rst), .START_I(start),
		.OPCODE_I(op), .DISP_I(disp), .PC_I(pc), .WREG_RD_I(wrd),
		.CODE_RD_I(crd), .IRQ_PENDING_I(pend), .FLAGS_I(flags),
		.BUSY_O(busy), .DONE_O(done), .WREG_SEL_O(wsel), .WREG_WE_O(wwe),
		.WREG_WD_O(wwd), .PC_WE_O(pwe), .PC_O(pco), .CODE_ADDR_O(cad),
		.STACK_WE_O(swe), .STACK_ADDR_O(sad), .STACK_WD_O(swd),
		.STACK_POINTER_O(sp), .INSTRUCTION_POINTER_O(ip),
		.SYSTEM_MODE_REG_O(mode), .FLAGS_O(flgo), .IRQ_TAKE_O(take),
		.IRQ_GRANT_O(grant));
	cbie_partner mem (.clk_i(clk), .rd_sel_i(op[7:4]), .rd_data_o(wrd),
		.wr_en_i(wwe), .wr_sel_i(wsel), .wr_data_i(wwd), .code_addr_i(cad),
		.code_data_o(crd), .stack_en_i(swe), .stack_addr_i(sad),
		.stack_data_i(swd));
	// ****
	// Checking
	// ****
	task automatic chk(input logic [43:0] got, input logic [43:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic pop(input logic [43:0] got);
		if (q.size() == 0) chk(got, 44'hx);
		else chk(got, q.pop_front());
	endtask : pop
	task automatic wrap_up;
		if (q.size() != 0) bad_count++;
		$display("Compares %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	// Fixed pop order per cycle matches the order notes are queued
	always @(negedge clk) begin
		if (!rst) begin
			chk({36'h0, flgo}, {36'h0, flags});
			if (wwe) pop({4'h1, 28'h0, wsel, wwd});
			if (pwe) pop({4'h2, 24'h0, pco});
			if (swe) pop({4'h3, 16'h0, sad, swd});
			if (done) pop({4'h4, sp, ip, mode});
			if (!busy) chk({43'h0, take}, {43'h0, irq_on && pend != 0});
			if (take) chk({36'h0, grant}, {36'h0, pend & (~pend + 8'h01)});
		end
	end
	// ****
	// Stimulus
	// ****
	task automatic run(input logic [7:0] o, input logic [7:0] d,
		input logic [3:0] cyc, input bit hold);
		@(posedge clk);
		start <= 1;
		op <= o;
		disp <= d;
		pc <= 16'($random(seed));
		flags <= 8'($random(seed));
		pend <= 8'($random(seed)) | 8'h20;
		@(posedge clk);
		start <= hold;
		if (o[3:0] == CBIE_LOOP_OP_LO) begin
			r = mem.wreg[o[7:4]] - 8'h01;
			q.push_back({4'h1, 28'h0, o[7:4], r});
			if (r != 8'h00) q.push_back({4'h2, 24'h0, pc + {{8{d[7]}}, d}});
		end else if (o == CBIE_IRQ_EN_OP) begin
			emode[CBIE_IRQ_EN_BIT] = 1'b1;
		end else begin
			esp = esp - CBIE_PTR_STEP;
			q.push_back({4'h3, 16'h0, esp, eip[15:8]});
			q.push_back({4'h3, 16'h0, esp + 16'h1, eip[7:0]});
			q.push_back({4'h2, 24'h0, mem.code[pc], mem.code[pc + 16'h1]});
			eip = pc + CBIE_PTR_STEP;
		end
		q.push_back({4'h4, esp, eip, emode});
		@(posedge clk);
		start <= 0;
		n = 1;
		while (n < 20) begin
			@(negedge clk);
			n++;
			if (done) break;
		end
		if (n >= 20) begin
			bad_count++;
			wrap_up();
		end
		chk({40'h0, n[3:0]}, {40'h0, cyc - 4'h1});
		if (o == CBIE_IRQ_EN_OP) irq_on = 1;
	endtask : run
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		@(negedge clk);
		chk({4'h4, sp, ip, mode}, {4'h4, esp, eip, emode});
		mem.wreg[3] = 8'h01;
		mem.wreg[4] = 8'h00;
		// Odd registers hold start high into a busy cycle, which is ignored
		for (int i = 0; i < 16; i++) begin
			run({i[3:0], CBIE_LOOP_OP_LO}, i[0] ? 8'h80 : 8'h7f,
				CBIE_LOOP_CYCLES, i[0]);
		end
		run(CBIE_ENTER_OP, 8'h00, CBIE_ENTER_CYCLES, 1'b0);
		run(CBIE_ENTER_OP, 8'h00, CBIE_ENTER_CYCLES, 1'b1);
		@(posedge clk);
		start <= 1;
		op <= 8'h00;
		@(posedge clk);
		start <= 0;
		repeat (3) begin
			@(negedge clk);
			chk({43'h0, busy}, 44'h0);
		end
		run(CBIE_IRQ_EN_OP, 8'h00, CBIE_IRQ_EN_CYCLES, 1'b0);
		run(CBIE_ENTER_OP, 8'h00, CBIE_ENTER_CYCLES, 1'b0);
		run(8'h5a, 8'h80, CBIE_LOOP_CYCLES, 1'b0);
		repeat (3) @(posedge clk);
		wrap_up();
	end
endmodule : cbie_exec_bench
